// ==== cct_pkg.sv ====
package cct_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_PER_LO  = 8'h14;
  localparam logic [7:0] OFS_PER_MID = 8'h15;
  localparam logic [7:0] OFS_PER_HI  = 8'h16;
  localparam logic [7:0] OFS_DIS_LO  = 8'h17;
  localparam logic [7:0] OFS_TRIG    = 8'h18;
  localparam logic [7:0] OFS_PRE_LO  = 8'h19;
  localparam logic [7:0] OFS_WARM    = 8'h1A;
  localparam logic [7:0] OFS_FULL_LO = 8'h1B;
  localparam logic [7:0] OFS_NVM     = 8'h1C;
  localparam logic [7:0] OFS_ALT_LO  = 8'h40;
  localparam logic [7:0] OFS_STATUS  = 8'h43;
  localparam int CFG_N = 9;
  localparam int ALT_N = 3;
  localparam logic [7:0] RST_REG = 8'h00;
  // Reserved bits are masked on write so they read as zero
  localparam logic [CFG_N-1:0][7:0] CFG_MASK =
    {8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF};
  localparam logic [ALT_N-1:0][7:0] ALT_MASK = {8'h7F, 8'hFF, 8'hFF};
  // ==========================================================
  // Field layout
  localparam int PER_W    = 23;
  localparam int PER_HI_W = 7;
  localparam int TIME_W   = 10;
  localparam int HI_W     = 2;
  localparam int WARM_W   = 4;
  localparam int WARM_LSB = 2;
  localparam int SRC_LSB  = 2;
  localparam int ALT_LSB  = 4;
  localparam int PIN_LSB  = 6;
  localparam int NVM_SINGLE_BIT = 7;
  localparam int NVM_WRITE_BIT  = 6;
  localparam int NVM_OFF_BIT    = 5;
  localparam int NVM_SETUP_BIT  = 3;
  localparam int NVM_AWAKE_BIT  = 2;
  localparam logic [1:0] TRG_STRETCH = 2'h0;
  localparam logic [1:0] TRG_CONT    = 2'h1;
  localparam logic [1:0] TRG_TIMER   = 2'h2;
  localparam logic [1:0] TRG_PIN     = 2'h3;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ         = 200;
  localparam int NVM_LONG_NS     = 10000;
  localparam int NVM_LONG_CYC    = (NVM_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int NVM_SHORT_EDGES = 3;
  localparam int NCNT_W          = 12;
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_DIS, SEQ_PRE, SEQ_FULL, SEQ_DONE} cct_seq_e;
  typedef enum logic [0:0] {NVM_IDLE, NVM_WAKE} cct_nvm_e;
endpackage

// ==== cct_seq_if.sv ====
`timescale 1ns/10ps
interface cct_seq_if;
  logic                       start;
  logic                       cyc_tick;
  logic [cct_pkg::TIME_W-1:0] dis_time;
  logic [cct_pkg::TIME_W-1:0] pre_time;
  logic [cct_pkg::TIME_W-1:0] full_time;
  logic [cct_pkg::WARM_W-1:0] warm_cnt;
  logic                       busy;
  logic                       meas_strobe;
  logic                       meas_warm;
  logic                       seq_done;
  modport ctl (output start, cyc_tick, dis_time, pre_time, full_time, warm_cnt,
               input busy, meas_strobe, meas_warm, seq_done);
  modport seq (input start, cyc_tick, dis_time, pre_time, full_time, warm_cnt,
               output busy, meas_strobe, meas_warm, seq_done);
endinterface

// ==== cct_seq.sv ====
`timescale 1ns/10ps
module cct_seq (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Settings and status
  cct_seq_if.seq   sif
);
  typedef struct packed {
    cct_pkg::cct_seq_e          st;
    logic [cct_pkg::TIME_W-1:0] cnt;
    logic [cct_pkg::WARM_W-1:0] warm;
    logic                       busy;
    logic                       strobe;
    logic                       wflag;
    logic                       done;
  } cct_seq_s;
  cct_seq_s q_reg;
  cct_seq_s q_next;

  // ==========================================================
  // Phase sequencer, one count per cycle-clock rise
  always_comb begin
    q_next = q_reg;
    q_next.strobe = 1'b0;
    q_next.done = 1'b0;
    case (q_reg.st)
      cct_pkg::SEQ_IDLE: if (sif.start) begin
        q_next.st = cct_pkg::SEQ_DIS;
        q_next.cnt = sif.dis_time;
        q_next.warm = sif.warm_cnt;
        q_next.busy = 1'b1;
      end
      cct_pkg::SEQ_DIS: if (sif.cyc_tick) begin
        if (q_reg.cnt != '0) begin
          q_next.cnt = q_reg.cnt - 1'b1;
        end else if (sif.pre_time != '0) begin
          q_next.st = cct_pkg::SEQ_PRE;
          q_next.cnt = sif.pre_time;
        end else if (sif.full_time != '0) begin
          q_next.st = cct_pkg::SEQ_FULL;
          q_next.cnt = sif.full_time;
        end else begin
          q_next.st = cct_pkg::SEQ_DONE;
        end
      end
      cct_pkg::SEQ_PRE: if (sif.cyc_tick) begin
        if (q_reg.cnt != '0) begin
          q_next.cnt = q_reg.cnt - 1'b1;
        end else if (sif.full_time != '0) begin
          q_next.st = cct_pkg::SEQ_FULL;
          q_next.cnt = sif.full_time;
        end else begin
          q_next.st = cct_pkg::SEQ_DONE;
        end
      end
      cct_pkg::SEQ_FULL: if (sif.cyc_tick) begin
        if (q_reg.cnt != '0) begin
          q_next.cnt = q_reg.cnt - 1'b1;
        end else begin
          q_next.st = cct_pkg::SEQ_DONE;
        end
      end
      cct_pkg::SEQ_DONE: begin
        q_next.strobe = 1'b1;
        q_next.wflag = (q_reg.warm != '0);
        if (q_reg.warm != '0) begin
          q_next.warm = q_reg.warm - 1'b1;
          q_next.st = cct_pkg::SEQ_DIS;
          q_next.cnt = sif.dis_time;
        end else begin
          q_next.done = 1'b1;
          q_next.busy = 1'b0;
          q_next.st = cct_pkg::SEQ_IDLE;
        end
      end
      default: q_next.st = cct_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) q_reg <= '0;
    else q_reg <= q_next;
  end

  assign sif.busy = q_reg.busy;
  assign sif.meas_strobe = q_reg.strobe;
  assign sif.meas_warm = q_reg.wflag;
  assign sif.seq_done = q_reg.done;

  // ==========================================================
  // Checks
  property p_dis_entry;
    @(posedge ref_clk) disable iff (!rst_n)
    (q_reg.st == cct_pkg::SEQ_IDLE && sif.start)
      |=> (q_reg.st == cct_pkg::SEQ_DIS && q_reg.cnt == $past(sif.dis_time));
  endproperty
  a_dis_entry: assert property (p_dis_entry) else $error("discharge entry wrong");
  property p_no_pre;
    @(posedge ref_clk) disable iff (!rst_n)
    (q_reg.st == cct_pkg::SEQ_DIS && sif.cyc_tick && q_reg.cnt == '0 && sif.pre_time == '0)
      |=> q_reg.st != cct_pkg::SEQ_PRE;
  endproperty
  a_no_pre: assert property (p_no_pre) else $error("precharge not skipped");
  property p_warm_last;
    @(posedge ref_clk) disable iff (!rst_n)
    sif.seq_done |-> (sif.meas_strobe && !sif.meas_warm);
  endproperty
  a_warm_last: assert property (p_warm_last) else $error("last result flagged warm-up");
endmodule

// ==== cct_top.sv ====
// Operation
// - Bank select picks second period value
// - Discharge lasts setting plus one cycles
// - Discharge bits split across two registers
// - Precharge setting plus one, zero skips
// - Full charge setting plus one, zero skips
// - Warm-up measurements run first, results flagged
// - Trigger field: stretched, continuous, timer, pin
// - Two-bit field selects one of four pins
// - Trigger register holds alternate trigger source
// - Single write needs both permit bits
// - Write permit low blocks writes, erases
// - Memory off bit blocks all access
// - Setup select: 1.5 oscillator periods or 10us
// - Keep-awake bit holds memory awake
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps

module cct_top (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Signal processor
  input  wire logic       dsp_bank_sel,
  input  wire logic       trig_cmd,
  // Asynchronous pins
  input  wire logic       olf_clk_pin,
  input  wire logic       cycle_clk_pin,
  input  wire logic [3:0] gpio_pin,
  // Measurement status
  output logic            meas_start,
  output logic            meas_valid,
  output logic            meas_warmup,
  output logic            seq_done,
  output logic            conv_busy,
  // Memory access
  input  wire logic       nvm_req,
  input  wire logic       nvm_req_write,
  input  wire logic       nvm_req_single,
  output logic            nvm_grant,
  output logic            nvm_refuse,
  output logic            nvm_awake,
  output logic            nvm_read_en,
  output logic            nvm_write_en,
  output logic            nvm_single_en
);
  localparam int I_PER_MID = int'(cct_pkg::OFS_PER_MID - cct_pkg::OFS_PER_LO);
  localparam int I_PER_HI  = int'(cct_pkg::OFS_PER_HI - cct_pkg::OFS_PER_LO);
  localparam int I_DIS     = int'(cct_pkg::OFS_DIS_LO - cct_pkg::OFS_PER_LO);
  localparam int I_TRIG    = int'(cct_pkg::OFS_TRIG - cct_pkg::OFS_PER_LO);
  localparam int I_PRE     = int'(cct_pkg::OFS_PRE_LO - cct_pkg::OFS_PER_LO);
  localparam int I_WARM    = int'(cct_pkg::OFS_WARM - cct_pkg::OFS_PER_LO);
  localparam int I_FULL    = int'(cct_pkg::OFS_FULL_LO - cct_pkg::OFS_PER_LO);
  localparam int I_NVM     = int'(cct_pkg::OFS_NVM - cct_pkg::OFS_PER_LO);
  localparam int PW        = cct_pkg::PER_W;
  localparam int NW        = cct_pkg::NCNT_W;

  typedef struct packed {
    logic [cct_pkg::CFG_N-1:0][7:0] cfg;
    logic [cct_pkg::ALT_N-1:0][7:0] alt;
    logic [7:0]                     rdata;
    logic [2:0]                     olf_s;
    logic [2:0]                     cyc_s;
    logic [3:0]                     gp_s1;
    logic [3:0]                     gp_s2;
    logic [3:0]                     gp_prev;
    logic [PW:0]                    tmr;
    logic                           start;
    cct_pkg::cct_nvm_e              nst;
    logic [NW-1:0]                  ncnt;
    logic                           long_sel;
    logic                           awake;
    logic                           grant;
    logic                           refuse;
    logic                           rd_en;
    logic                           wr_en;
    logic                           single_en;
  } cct_top_s;

  cct_top_s q_reg;
  cct_top_s q_next;

  cct_seq_if sif ();

  // ==========================================================
  // Decoded settings
  logic [PW-1:0]  per_main;
  logic [PW-1:0]  per_alt;
  logic [PW-1:0]  per_sel;
  logic [1:0]     src_main;
  logic [1:0]     src_alt;
  logic [1:0]     trig_src;
  logic [1:0]     pin_sel;
  logic           single_permit;
  logic           write_permit;
  logic           nvm_off;
  logic           setup_sel;
  logic           keep_awake;
  logic [7:0]     status;

  assign per_main = {q_reg.cfg[I_PER_HI][cct_pkg::PER_HI_W-1:0],
                     q_reg.cfg[I_PER_MID], q_reg.cfg[0]};
  assign per_alt = {q_reg.alt[2][cct_pkg::PER_HI_W-1:0],
                    q_reg.alt[1], q_reg.alt[0]};
  assign per_sel = dsp_bank_sel ? per_alt : per_main;
  assign src_main = q_reg.cfg[I_TRIG][cct_pkg::SRC_LSB +: 2];
  assign src_alt = q_reg.cfg[I_TRIG][cct_pkg::ALT_LSB +: 2];
  assign trig_src = dsp_bank_sel ? src_alt : src_main;
  assign pin_sel = q_reg.cfg[I_TRIG][cct_pkg::PIN_LSB +: 2];
  assign single_permit = q_reg.cfg[I_NVM][cct_pkg::NVM_SINGLE_BIT];
  assign write_permit = q_reg.cfg[I_NVM][cct_pkg::NVM_WRITE_BIT];
  assign nvm_off = q_reg.cfg[I_NVM][cct_pkg::NVM_OFF_BIT];
  assign setup_sel = q_reg.cfg[I_NVM][cct_pkg::NVM_SETUP_BIT];
  assign keep_awake = q_reg.cfg[I_NVM][cct_pkg::NVM_AWAKE_BIT];

  // High bits of each 10-bit time sit in the low bits of the next byte
  assign sif.dis_time = {q_reg.cfg[I_TRIG][cct_pkg::HI_W-1:0],
                         q_reg.cfg[I_DIS]};
  assign sif.pre_time = {q_reg.cfg[I_WARM][cct_pkg::HI_W-1:0],
                         q_reg.cfg[I_PRE]};
  assign sif.full_time = {q_reg.cfg[I_NVM][cct_pkg::HI_W-1:0],
                          q_reg.cfg[I_FULL]};
  assign sif.warm_cnt = q_reg.cfg[I_WARM][cct_pkg::WARM_LSB +: cct_pkg::WARM_W];
  assign sif.start = q_reg.start;

  assign status = {4'h0, q_reg.awake, (q_reg.nst != cct_pkg::NVM_IDLE),
                   sif.busy, dsp_bank_sel};

  // ==========================================================
  // Pin edges, from second and third stages only
  logic       olf_rise;
  logic       olf_any;
  logic [3:0] gp_rise;
  logic       pin_hit;

  assign olf_rise = q_reg.olf_s[1] & ~q_reg.olf_s[2];
  assign olf_any = q_reg.olf_s[1] ^ q_reg.olf_s[2];
  assign gp_rise = q_reg.gp_s2 & ~q_reg.gp_prev;
  assign pin_hit = gp_rise[pin_sel];
  assign sif.cyc_tick = q_reg.cyc_s[1] & ~q_reg.cyc_s[2];

  // ==========================================================
  // Start selection
  logic tmr_hit;
  logic src_req;
  logic start_free;
  logic req_ok;

  // Timer counts oscillator rises, so a period is 2*setting rises
  assign tmr_hit = olf_rise &&
                   (({1'b0, q_reg.tmr} + {{PW + 1{1'b0}}, 1'b1}) >=
                    {1'b0, per_sel, 1'b0});
  // A start is ignored while a sequence runs; no queueing
  assign start_free = !sif.busy && !q_reg.start;

  always_comb begin
    case (trig_src)
      cct_pkg::TRG_STRETCH: src_req = tmr_hit;
      cct_pkg::TRG_CONT:    src_req = 1'b1;
      cct_pkg::TRG_TIMER:   src_req = tmr_hit;
      cct_pkg::TRG_PIN:     src_req = pin_hit;
      default:              src_req = 1'b0;
    endcase
  end

  // ==========================================================
  // Memory access permission
  always_comb begin
    if (!nvm_req_write) begin
      req_ok = !nvm_off;
    end else if (nvm_req_single) begin
      req_ok = single_permit && write_permit && !nvm_off;
    end else begin
      req_ok = write_permit && !nvm_off;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    q_next = q_reg;
    q_next.olf_s = {q_reg.olf_s[1:0], olf_clk_pin};
    q_next.cyc_s = {q_reg.cyc_s[1:0], cycle_clk_pin};
    q_next.gp_s1 = gpio_pin;
    q_next.gp_s2 = q_reg.gp_s1;
    q_next.gp_prev = q_reg.gp_s2;

    for (int i = 0; i < cct_pkg::CFG_N; i++) begin
      if (reg_wr && reg_addr == cct_pkg::OFS_PER_LO + 8'(i)) begin
        q_next.cfg[i] = reg_wdata & cct_pkg::CFG_MASK[i];
      end
    end
    for (int j = 0; j < cct_pkg::ALT_N; j++) begin
      if (reg_wr && reg_addr == cct_pkg::OFS_ALT_LO + 8'(j)) begin
        q_next.alt[j] = reg_wdata & cct_pkg::ALT_MASK[j];
      end
    end

    q_next.rdata = 8'h00;
    if (reg_rd) begin
      for (int k = 0; k < cct_pkg::CFG_N; k++) begin
        if (reg_addr == cct_pkg::OFS_PER_LO + 8'(k)) q_next.rdata = q_reg.cfg[k];
      end
      for (int m = 0; m < cct_pkg::ALT_N; m++) begin
        if (reg_addr == cct_pkg::OFS_ALT_LO + 8'(m)) q_next.rdata = q_reg.alt[m];
      end
      if (reg_addr == cct_pkg::OFS_STATUS) q_next.rdata = status;
    end

    // Stretched mode measures the period from each start
    q_next.start = start_free && (trig_cmd || src_req);
    if (q_next.start && trig_src == cct_pkg::TRG_STRETCH) begin
      q_next.tmr = '0;
    end else if (olf_rise) begin
      q_next.tmr = tmr_hit ? '0 : q_reg.tmr + 1'b1;
    end

    q_next.grant = 1'b0;
    q_next.refuse = 1'b0;
    q_next.rd_en = !nvm_off;
    q_next.wr_en = write_permit && !nvm_off;
    q_next.single_en = single_permit && write_permit && !nvm_off;
    case (q_reg.nst)
      cct_pkg::NVM_IDLE: begin
        if (nvm_off || !keep_awake) q_next.awake = 1'b0;
        if (nvm_req) begin
          if (!req_ok) begin
            q_next.refuse = 1'b1;
          end else if (q_reg.awake && keep_awake) begin
            q_next.grant = 1'b1;
          end else begin
            q_next.nst = cct_pkg::NVM_WAKE;
            q_next.awake = 1'b1;
            q_next.long_sel = setup_sel;
            q_next.ncnt = setup_sel ? NW'(cct_pkg::NVM_LONG_CYC - 1)
                                    : NW'(cct_pkg::NVM_SHORT_EDGES - 1);
          end
        end
      end
      cct_pkg::NVM_WAKE: begin
        if (nvm_off) begin
          q_next.nst = cct_pkg::NVM_IDLE;
          q_next.awake = 1'b0;
          q_next.refuse = 1'b1;
        end else if (q_reg.long_sel || olf_any) begin
          // Short setup counts both oscillator edges: three is 1.5 periods
          if (q_reg.ncnt == '0) begin
            q_next.grant = 1'b1;
            q_next.nst = cct_pkg::NVM_IDLE;
          end else begin
            q_next.ncnt = q_reg.ncnt - 1'b1;
          end
        end
      end
      default: q_next.nst = cct_pkg::NVM_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q_reg <= '0;
      q_reg.cfg <= {cct_pkg::CFG_N{cct_pkg::RST_REG}};
      q_reg.alt <= {cct_pkg::ALT_N{cct_pkg::RST_REG}};
    end else begin
      q_reg <= q_next;
    end
  end

  // ==========================================================
  // Sequencer
  cct_seq u_seq (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .sif     (sif.seq)
  );

  // ==========================================================
  // Outputs
  assign reg_rdata = q_reg.rdata;
  assign meas_start = q_reg.start;
  assign meas_valid = sif.meas_strobe;
  assign meas_warmup = sif.meas_warm;
  assign seq_done = sif.seq_done;
  assign conv_busy = sif.busy;
  assign nvm_grant = q_reg.grant;
  assign nvm_refuse = q_reg.refuse;
  assign nvm_awake = q_reg.awake;
  assign nvm_read_en = q_reg.rd_en;
  assign nvm_write_en = q_reg.wr_en;
  assign nvm_single_en = q_reg.single_en;

  // ==========================================================
  // Checks
  property p_rdata_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside slot");
  property p_dis_split;
    @(posedge ref_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == cct_pkg::OFS_TRIG)
      |=> sif.dis_time[9:8] == $past(reg_wdata[1:0]);
  endproperty
  a_dis_split: assert property (p_dis_split) else $error("discharge high bits lost");
  property p_per_hi;
    @(posedge ref_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == cct_pkg::OFS_PER_HI)
      |=> per_main[22:16] == $past(reg_wdata[6:0]);
  endproperty
  a_per_hi: assert property (p_per_hi) else $error("period top byte misplaced");
  property p_timer;
    @(posedge ref_clk) disable iff (!rst_n)
    (tmr_hit && trig_src == cct_pkg::TRG_TIMER && start_free) |=> meas_start;
  endproperty
  a_timer: assert property (p_timer) else $error("timer start lost");
  property p_cont;
    @(posedge ref_clk) disable iff (!rst_n)
    (trig_src == cct_pkg::TRG_CONT && start_free) |=> meas_start;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous restart missing");
  property p_pin;
    @(posedge ref_clk) disable iff (!rst_n)
    (trig_src == cct_pkg::TRG_PIN && start_free && gp_rise[pin_sel]) |=> meas_start;
  endproperty
  a_pin: assert property (p_pin) else $error("pin start missing");
  property p_cmd;
    @(posedge ref_clk) disable iff (!rst_n)
    (trig_cmd && start_free) |=> meas_start ##1 !meas_start;
  endproperty
  a_cmd: assert property (p_cmd) else $error("trigger command ignored");
  property p_wr_block;
    @(posedge ref_clk) disable iff (!rst_n)
    (q_reg.nst == cct_pkg::NVM_IDLE && nvm_req && nvm_req_write && !write_permit)
      |=> (nvm_refuse && !nvm_grant);
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write not blocked");
  property p_single;
    @(posedge ref_clk) disable iff (!rst_n)
    (q_reg.nst == cct_pkg::NVM_IDLE && nvm_req && nvm_req_write && nvm_req_single
      && !(single_permit && write_permit)) |=> nvm_refuse;
  endproperty
  a_single: assert property (p_single) else $error("single write not blocked");
  property p_off;
    @(posedge ref_clk) disable iff (!rst_n)
    (q_reg.nst == cct_pkg::NVM_IDLE && nvm_req && nvm_off) |=> nvm_refuse;
  endproperty
  a_off: assert property (p_off) else $error("access while memory off");
  property p_long;
    @(posedge ref_clk) disable iff (!rst_n)
    (q_reg.nst == cct_pkg::NVM_IDLE && nvm_req && req_ok && setup_sel
      && !(q_reg.awake && keep_awake))
      |=> (q_reg.ncnt == NW'(cct_pkg::NVM_LONG_CYC - 1) && !nvm_grant) [*1]
      ##1 (!nvm_grant) [*8];
  endproperty
  a_long: assert property (p_long) else $error("long setup too short");
  property p_sleep;
    @(posedge ref_clk) disable iff (!rst_n)
    (nvm_grant && !keep_awake && !nvm_req) |=> !nvm_awake;
  endproperty
  a_sleep: assert property (p_sleep) else $error("memory not put to sleep");
endmodule

// ==== cct_far.sv ====
`timescale 1ns/10ps
// ==========================================
// Sensor-side oscillators and trigger pins
module cct_far (
  // Pins toward the block
  output logic            olf_clk,
  output logic            cyc_clk,
  output logic      [3:0] gpio,
  // Bench request
  input  wire logic [3:0] fire
);
  // Oscillators run free; unrelated in phase to ref_clk
  initial begin
    olf_clk = 1'b0;
    cyc_clk = 1'b0;
  end
  always #100 olf_clk = ~olf_clk;
  always #27 cyc_clk = ~cyc_clk;
  assign gpio = fire;
endmodule

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
  logic       ref_clk, rst_n, reg_wr, reg_rd, bank, trig, nreq, nwr, nsgl;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       olf, cyc, ms, mv, mw, sd, busy, gr, rf, aw, ren, wen, sen;
  logic [3:0] gpio, fire;
  int         miscompares = 0;
  int         checks = 0;
  cct_top cct_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dsp_bank_sel(bank), .trig_cmd(trig), .olf_clk_pin(olf), .cycle_clk_pin(cyc),
    .gpio_pin(gpio), .meas_start(ms), .meas_valid(mv), .meas_warmup(mw),
    .seq_done(sd), .conv_busy(busy), .nvm_req(nreq), .nvm_req_write(nwr),
    .nvm_req_single(nsgl), .nvm_grant(gr), .nvm_refuse(rf), .nvm_awake(aw),
    .nvm_read_en(ren), .nvm_write_en(wen), .nvm_single_en(sen));
  cct_far cct_far_i (.olf_clk(olf), .cyc_clk(cyc), .gpio(gpio), .fire(fire));
  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_hi(input string nm, ref logic s, input int k);
    int n;
    for (n = 0; n < k && s !== 1'b1; n++) tick;
    if (n >= k) begin
      $display("CHECK FAILED %s expected 1 seen 0", nm);
      miscompares++;
      close_out;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, exp);
  endtask
  // Memory request; g picks grant or refusal, k the awake level after grant
  task automatic req(input logic w, input logic s, input logic g, input logic k);
    @(posedge ref_clk);
    nreq <= 1'b1;
    nwr  <= w;
    nsgl <= s;
    @(posedge ref_clk);
    nreq <= 1'b0;
    #1;
    if (g) begin
      wait_hi("nvm_grant", gr, 3000);
      chk("nvm_awake", aw, 1'b1);
      tick;
      chk("nvm_awake", aw, k);
    end else chk("nvm_refuse", rf, 1'b1);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    logic [7:0] m [9] = '{8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF};
    logic [7:0] z [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h8C, 8'h00, 8'h04, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) wr(8'h14 + 8'(i), 8'hFF);
    for (int i = 0; i < 9; i++) rd(8'h14 + 8'(i), m[i]);
    rd(8'h30, 8'h00);
    // Pin source on an idle pin, one warm-up, shortest intervals
    for (int i = 0; i < 9; i++) wr(8'h14 + 8'(i), z[i]);
    $display("register map done");
  endtask
  task automatic t_cmd;
    @(posedge ref_clk) trig <= 1'b1;
    @(posedge ref_clk) trig <= 1'b0;
    #1 chk("meas_start", ms, 1'b1);
    tick;
    chk("conv_busy", busy, 1'b1);
    wait_hi("meas_valid", mv, 500);
    chk("meas_warmup", mw, 1'b1);
    chk("seq_done", sd, 1'b0);
    tick;
    wait_hi("meas_valid", mv, 500);
    chk("meas_warmup", mw, 1'b0);
    chk("seq_done", sd, 1'b1);
    chk("conv_busy", busy, 1'b0);
    $display("trigger command done");
  endtask
  task automatic t_pin;
    int hits = 0;
    @(posedge ref_clk) fire <= 4'h2;
    repeat (20) begin
      tick;
      hits += int'(ms === 1'b1);
    end
    chk("meas_start", 8'(hits), 8'h00);
    @(posedge ref_clk) fire <= 4'h4;
    #1 wait_hi("meas_start", ms, 20);
    fire <= 4'h0;
    wait_hi("seq_done", sd, 1000);
    $display("pin trigger done");
  endtask
  task automatic t_bank;
    // Continuous restart, then back to the idle pin
    wr(8'h18, 8'h84);
    #1 wait_hi("meas_start", ms, 4);
    wr(8'h18, 8'h8C);
    wait_hi("seq_done", sd, 1000);
    wr(8'h42, 8'hFF);
    rd(8'h42, 8'h7F);
    wr(8'h42, 8'h00);
    // Main period huge, second bank zero: only the second bank can fire
    wr(8'h16, 8'h7F);
    wr(8'h18, 8'hBC);
    @(posedge ref_clk) bank <= 1'b1;
    rd(8'h43, 8'h01);
    wr(8'h18, 8'hAC);
    #1 wait_hi("meas_start", ms, 60);
    @(posedge ref_clk) bank <= 1'b0;
    wait_hi("seq_done", sd, 1000);
    $display("second bank done");
  endtask
  task automatic t_nvm;
    wr(8'h1C, 8'h00);
    req(1'b1, 1'b0, 1'b0, 1'b0);
    chk("nvm_write_en", wen, 1'b0);
    wr(8'h1C, 8'h20);
    req(1'b0, 1'b0, 1'b0, 1'b0);
    chk("nvm_read_en", ren, 1'b0);
    wr(8'h1C, 8'h80);
    req(1'b1, 1'b1, 1'b0, 1'b0);
    chk("nvm_single_en", sen, 1'b0);
    wr(8'h1C, 8'h40);
    req(1'b1, 1'b0, 1'b1, 1'b0);
    wr(8'h1C, 8'hC0);
    req(1'b1, 1'b1, 1'b1, 1'b0);
    chk("nvm_single_en", sen, 1'b1);
    chk("nvm_write_en", wen, 1'b1);
    chk("nvm_read_en", ren, 1'b1);
    // Long setup: about 2000 cycles to grant
    wr(8'h1C, 8'h48);
    req(1'b0, 1'b0, 1'b1, 1'b0);
    // Kept awake: first access wakes it, the next finds it awake
    wr(8'h1C, 8'h44);
    req(1'b0, 1'b0, 1'b1, 1'b1);
    req(1'b0, 1'b0, 1'b1, 1'b1);
    $display("memory access done");
  endtask
  // ==========================================
  // Clock and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    {rst_n, reg_wr, reg_rd, bank, trig, nreq, nwr, nsgl} = '0;
    {reg_addr, reg_wdata, fire} = '0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs;
    t_cmd;
    t_pin;
    t_bank;
    t_nvm;
    close_out;
  end
endmodule
